// *** inc/rfi_pkg.sv ***
// Constants, register map and request carrier for the regulator fault interrupt registers.
// Assumes a serial control port engine elsewhere that turns bus transfers into byte accesses.
//
// How it works
// - Status 0x11 latches six rail faults, write-one-clears.
// - Mask 0x12 holds six bits, reset all ones.
// - Sense 0x13 shows six live rail faults.
// - Sense bit 1 means current above limit.
// - Sense 0x10 bit 2 shows supply overvoltage.
// - Bits 7 and 6 read as zero.
// - Writing one clears a flag, zero keeps it.
// - Mask zero lets a flag reach the pin.
package rfi_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_SUPPLY_OV_SENSE = 8'h10;
    localparam logic [7:0] ADDR_LDO_OC_STATUS = 8'h11;
    localparam logic [7:0] ADDR_LDO_OC_MASK = 8'h12;
    localparam logic [7:0] ADDR_LDO_OC_SENSE = 8'h13;

    // ==========================================================
    // Field layout and reset values
    localparam int RAIL_COUNT = 6;
    localparam int SUPPLY_OV_BIT = 2;
    localparam logic [5:0] STATUS_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h3f;
    localparam logic [5:0] SENSE_RESET = 6'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Byte access from the control port engine
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rfi_req_t;

endpackage : rfi_pkg

// *** logic/rfi_sync.sv ***
// Two-stage synchroniser for the analog fault comparator levels.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/100ps
module rfi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // A zero width would leave the level ports without a single bit.
    if (WIDTH < 1) begin : g_width_bad
        $error("rfi_sync needs WIDTH of at least one");
    end

    // The first stage feeds only the second, so metastability never reaches logic.
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule : rfi_sync

// *** logic/rfi_regs.sv ***
// Interrupt status, mask and sense registers for the linear regulator overcurrent faults.
// Assumes byte accesses from the control port engine on clk and raw comparator levels.
`timescale 1ns/100ps
module rfi_regs #(
    parameter int RAILS = rfi_pkg::RAIL_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register access
    input rfi_pkg::rfi_req_t req,
    output logic [7:0] rdata,
    // Fault comparators
    input wire logic [RAILS-1:0] ldo_fault_raw,
    input wire logic front_supply_ov_raw,
    // Interrupt pin
    output logic irq_out_n
);

    // ==========================================================
    // Elaboration check
    // Status, mask and sense each pack the rails into bits 5 to 0 of one byte, so exactly six are served.
    if (RAILS != rfi_pkg::RAIL_COUNT) begin : g_rails_bad
        $error("rfi_regs serves exactly six rails in one byte");
    end

    // ==========================================================
    // Live fault levels
    logic [RAILS-1:0] ldo_sense;
    logic front_supply_ov_live;

    rfi_sync #(
        .WIDTH(RAILS + 1)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({front_supply_ov_raw, ldo_fault_raw}),
        .sync_out({front_supply_ov_live, ldo_sense})
    );

    // ==========================================================
    // Access decode
    function automatic logic hit(input rfi_pkg::rfi_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction : hit

    // Bits above the rails are unused and always read as zero.
    function automatic logic [7:0] rail_byte(input logic [RAILS-1:0] v);
        logic [7:0] b;
        b = rfi_pkg::READ_ZERO;
        b[RAILS-1:0] = v;
        return b;
    endfunction : rail_byte

    logic wr_status;
    logic wr_mask;
    logic [RAILS-1:0] clr_vec;

    assign wr_status = req.wr && hit(req, rfi_pkg::ADDR_LDO_OC_STATUS);
    assign wr_mask = req.wr && hit(req, rfi_pkg::ADDR_LDO_OC_MASK);
    assign clr_vec = wr_status ? req.wdata[RAILS-1:0] : '0;

    // ==========================================================
    // Status flags
    logic [RAILS-1:0] status_q;
    logic [RAILS-1:0] status_d;

    always_comb begin
        // A fault present in the clearing cycle keeps its flag set.
        status_d = (status_q & ~clr_vec) | ldo_sense;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= rfi_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================================
    // Mask bits
    logic [RAILS-1:0] mask_q;
    logic [RAILS-1:0] mask_d;

    always_comb begin
        mask_d = wr_mask ? req.wdata[RAILS-1:0] : mask_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= rfi_pkg::MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ==========================================================
    // Interrupt pin
    // Registered so the pin never glitches while status and mask settle.
    logic irq_n_q;
    logic irq_n_d;

    always_comb begin
        irq_n_d = ~|(status_q & ~mask_q);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    assign irq_out_n = irq_n_q;

    // ==========================================================
    // Read data
    // The byte holds between reads, as there is no valid flag beside it.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            rdata_d = rfi_pkg::READ_ZERO;
            unique case (req.addr)
                rfi_pkg::ADDR_SUPPLY_OV_SENSE: begin
                    rdata_d[rfi_pkg::SUPPLY_OV_BIT] = front_supply_ov_live;
                end
                rfi_pkg::ADDR_LDO_OC_STATUS: begin
                    rdata_d = rail_byte(status_q);
                end
                rfi_pkg::ADDR_LDO_OC_MASK: begin
                    rdata_d = rail_byte(mask_q);
                end
                rfi_pkg::ADDR_LDO_OC_SENSE: begin
                    rdata_d = rail_byte(ldo_sense);
                end
                default: begin
                    rdata_d = rfi_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= rfi_pkg::READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ==========================================================
    // Checks
    // Reset checks carry their own disable, since reset is what they look at.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_stat_clear_one: assert property (
        wr_status |=> ((status_q & $past(clr_vec) & ~$past(ldo_sense)) == '0))
        else $error("written one did not clear a flag");

    a_stat_keep_zero: assert property (
        1 |=> ((($past(status_q) & ~$past(clr_vec)) & ~status_q) == '0))
        else $error("flag dropped without a written one");

    a_stat_set_wins: assert property (
        (ldo_sense != '0) |=> ((status_q & $past(ldo_sense)) == $past(ldo_sense)))
        else $error("live fault did not latch");

    a_stat_no_stray: assert property (
        1 |=> ((status_q & ~$past(status_q) & ~$past(ldo_sense)) == '0))
        else $error("flag set without a live fault");

    // ==========================================================
    // Mask checks
    a_mask_after_reset: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (mask_q == rfi_pkg::MASK_RESET && status_q == rfi_pkg::STATUS_RESET))
        else $error("mask or status reset value wrong");

    a_mask_write_takes: assert property (
        wr_mask |=> (mask_q == $past(req.wdata[RAILS-1:0])))
        else $error("mask write not taken");

    a_mask_no_stray: assert property (
        !wr_mask |=> (mask_q == $past(mask_q)))
        else $error("mask changed without a write");

    // ==========================================================
    // Sense checks
    a_sense_follows_pin: assert property (
        ##3 (ldo_sense == $past(ldo_fault_raw, 2)))
        else $error("sense does not follow fault level");

    a_ov_follows_pin: assert property (
        ##3 (front_supply_ov_live == $past(front_supply_ov_raw, 2)))
        else $error("overvoltage sense does not follow its level");

    a_sense_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (ldo_sense == '0 && !front_supply_ov_live))
        else $error("sense not zero after reset");

    // ==========================================================
    // Interrupt pin checks
    a_irq_active_low: assert property (
        (|(status_q & ~mask_q)) |=> !irq_out_n)
        else $error("interrupt pin not low for unmasked flag");

    a_irq_masked_high: assert property (
        !(|(status_q & ~mask_q)) |=> irq_out_n)
        else $error("interrupt pin low with no unmasked flag");

    a_irq_after_reset: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> irq_out_n)
        else $error("interrupt pin low after reset");

    // ==========================================================
    // Read data checks
    a_read_status_byte: assert property (
        (req.rd && hit(req, rfi_pkg::ADDR_LDO_OC_STATUS))
        |=> (rdata == {2'b00, $past(status_q)}))
        else $error("status read wrong");

    a_read_ov_byte: assert property (
        (req.rd && hit(req, rfi_pkg::ADDR_SUPPLY_OV_SENSE))
        |=> (rdata == ({7'h00, $past(front_supply_ov_live)} << rfi_pkg::SUPPLY_OV_BIT)))
        else $error("overvoltage sense read wrong");

    a_read_mask_byte: assert property (
        (req.rd && hit(req, rfi_pkg::ADDR_LDO_OC_MASK)) |=> (rdata == rail_byte($past(mask_q))))
        else $error("mask read wrong");

    a_read_sense_byte: assert property (
        (req.rd && hit(req, rfi_pkg::ADDR_LDO_OC_SENSE))
        |=> (rdata == rail_byte($past(ldo_sense))))
        else $error("sense read wrong");

    a_unmapped_zero: assert property (
        (req.rd && (req.addr < rfi_pkg::ADDR_SUPPLY_OV_SENSE
            || req.addr > rfi_pkg::ADDR_LDO_OC_SENSE)) |=> (rdata == rfi_pkg::READ_ZERO))
        else $error("unmapped read not zero");

    a_unused_zero: assert property (
        rdata[7:6] == 2'b00)
        else $error("unused bits not zero");

endmodule : rfi_regs

// *** dv/rfi_host_model.sv ***
// Host side model: single byte register reads and writes.
// Assumes the block takes a strobe on the edge after it is driven.
`timescale 1ns/100ps
module rfi_host_model (
    // Clock
    input wire logic clk,
    // Register access
    output rfi_pkg::rfi_req_t req
);
    // ========
    // Idle bus shows inverted data so a stale value cannot pass.
    initial req = '0;
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : xfer
endmodule : rfi_host_model

// *** dv/testbench.sv ***
// Testbench for the regulator fault interrupt registers.
// Assumes the host model drives the byte port and faults are slow levels.
`timescale 1ns/100ps
module testbench;
    // ========
    // Signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] fault = 6'h00;
    logic ov = 1'b0;
    logic irq_n;
    logic [7:0] rdata;
    rfi_pkg::rfi_req_t req;
    logic [31:0] seed = 32'h77f3;
    logic [5:0] st;
    logic [5:0] f;
    logic [5:0] m;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    rfi_host_model rfi_host_model_i (.clk(clk), .req(req));
    rfi_regs rfi_regs_i (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
        .ldo_fault_raw(fault), .front_supply_ov_raw(ov), .irq_out_n(irq_n));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end
    // ========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic exp_irq_n(input logic [5:0] s, input logic [5:0] k);
        return ~|(s & ~k);
    endfunction : exp_irq_n
    task automatic cmp_rdata(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("MISMATCH rdata at %h exp %h got %h", a, e, g);
        end
    endtask : cmp_rdata
    task automatic cmp_irq(input logic e, input logic g);
        checks = checks + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("MISMATCH irq_out_n exp %b got %b", e, g);
        end
    endtask : cmp_irq
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rfi_host_model_i.xfer(a, 8'h00, 1'b0);
        #1;
        cmp_rdata(a, e, rdata);
    endtask : rd
    task automatic finish_test();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // ========
    // Sequence
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        st = 6'h00;
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h3f);
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
        rfi_host_model_i.xfer(8'h12, 8'hff, 1'b1);
        rfi_host_model_i.xfer(8'h13, 8'hff, 1'b1);
        rfi_host_model_i.xfer(8'h10, 8'hff, 1'b1);
        rd(8'h10, 8'h00);
        rd(8'h12, 8'h3f);
        rd(8'h13, 8'h00);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            f = (i == 0) ? 6'h3f : seed[5:0];
            m = seed[13:8];
            @(posedge clk);
            fault <= f;
            ov <= seed[16];
            repeat (4) @(posedge clk);
            st = st | f;
            rd(8'h13, {2'b00, f});
            rd(8'h10, {5'h00, seed[16], 2'h0});
            if (i[0]) begin
                rfi_host_model_i.xfer(8'h11, 8'hff, 1'b1);
                st = f;
                rd(8'h11, {2'b00, st});
            end
            @(posedge clk);
            fault <= 6'h00;
            rfi_host_model_i.xfer(8'h12, {2'h3, m}, 1'b1);
            repeat (4) @(posedge clk);
            #1 cmp_irq(exp_irq_n(st, m), irq_n);
            rd(8'h11, {2'b00, st});
            rfi_host_model_i.xfer(8'h11, seed[31:24], 1'b1);
            st = st & ~seed[29:24];
            rd(8'h11, {2'b00, st});
        end
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1 cmp_irq(1'b1, irq_n);
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h3f);
        rd(8'h13, 8'h00);
        finish_test();
    end
endmodule : testbench
